// >>> common/pcr_pkg.sv
// package: constants, register map and types for power control and reset
// Overview of operation
// - codes 001b..111b select converter targets 1.2 V to 1.8 V, 0.1 V steps
// - scope bit 1: programmed level in transmit, fixed 1.4 V in receive
// - scope bit 0: programmed level used in receive and transmit
// - ratio enable 0: switching clock is digital clock divided by four
// - ratio enable 1: switching frequency is ratio word times clock over 2^15
// - digital clock equals crystal at 24-26 MHz, half crystal at 48-52 MHz
// - writable bypass bit picks high-performance or low-power regulator mode
// - power-up: reset held low a fixed pulse; registers return to default
// - same full reset pulse follows a shutdown pin step-down
// - internal reset level is visible on the first io pin
// - soft reset command performs only a partial reset
// - shutdown pin high asserts io disable signal
// - battery monitor may cut the amplifier; host enables or disables it
// - battery indicator offers four thresholds 2.1 V to 2.7 V in 0.2 V steps
package pcr_pkg;
  // byte addresses of the register words
  localparam logic [7:0] ADDR_SUPPLY_A = 8'h00;
  localparam logic [7:0] ADDR_SUPPLY_B = 8'h04;
  localparam logic [7:0] ADDR_RATIO_LO = 8'h08;
  localparam logic [7:0] ADDR_RATIO_HI = 8'h0C;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // supply_config_a_reg fields
  localparam int LVL_LSB = 0;
  localparam int LVL_W = 3;
  // supply_config_b_reg fields
  localparam int BYPASS_BIT = 1;
  localparam int SCOPE_BIT = 2;
  // switch_ratio_high_reg fields
  localparam int RATIO_EN_BIT = 7;
  localparam int RATIO_W = 15;
  // control register fields
  localparam int SOFT_RST_BIT = 0;
  localparam int BAT_PROT_BIT = 1;
  localparam int BAT_THR_LSB = 2;
  localparam int DIV2_BIT = 4;
  // reset values
  localparam logic [2:0] LVL_RST = 3'h3;
  localparam logic [14:0] RATIO_RST = 15'h07FC;
  localparam logic [2:0] LVL_FIXED_RX = 3'h3; // 1.4 V
  localparam logic [2:0] LVL_LOW = 3'h1; // 1.2 V
  // millivolt targets
  localparam logic [11:0] MV_BASE = 12'h4B0; // 1200 mV
  localparam logic [11:0] MV_STEP = 12'h064; // 100 mV
  localparam logic [11:0] BAT_MV_BASE = 12'h834; // 2100 mV
  localparam logic [11:0] BAT_MV_STEP = 12'h0C8; // 200 mV
  // timing: clock 10 MHz
  localparam int CLK_KHZ = 10000;
  localparam int RESET_US = 720; // 0.72 ms
  localparam int RESET_CYC = RESET_US * CLK_KHZ / 1000;
  localparam int DIV_FIXED = 4;
  localparam int SOFT_RST_CYC = 4;
  typedef enum logic [1:0] {
    PCR_ST_HOLD = 2'b00,
    PCR_ST_RUN = 2'b01,
    PCR_ST_SOFT = 2'b11
  } pcr_rst_e;
endpackage : pcr_pkg

// >>> hdl/pcr_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module pcr_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic aclk,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (ce) begin
          s1_r[i] <= d[i];
          q[i] <= s1_r[i];
        end
      end
    end
  endgenerate
endmodule : pcr_sync
`default_nettype wire

// >>> hdl/pcr_swclk.sv
// converter switching clock: fixed divide or ratio accumulator
`timescale 1ns/100ps
`default_nettype none
module pcr_swclk #(
  parameter int RW = 15
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // control
  input wire logic ratio_en,
  input wire logic [RW-1:0] ratio,
  // output
  output logic sw_clk
);
  logic [1:0] div_r;
  logic [RW:0] acc_r;
  logic [RW:0] acc_nxt;
  assign acc_nxt = {1'b0, acc_r[RW-1:0]} + {1'b0, ratio};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 2'h0;
      acc_r <= '0;
      sw_clk <= 1'b0;
    end else if (ce) begin
      div_r <= div_r + 2'h1;
      acc_r <= acc_nxt;
      if (ratio_en)
        sw_clk <= acc_r[RW-1];
      else
        sw_clk <= div_r[1];
    end
  end
endmodule : pcr_swclk
`default_nettype wire

// >>> hdl/pcr_top.sv
// power control and reset block with AXI4-Lite register slave
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module pcr_top #(
  parameter int RESET_CYCLES = pcr_pkg::RESET_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // pins
  input wire logic shutdown_pin,
  input wire logic battery_low,
  input wire logic tx_state,
  input wire logic rx_state,
  // axi write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power outputs
  output logic [2:0] converter_level_code,
  output logic [11:0] converter_mv,
  output logic converter_sw_clk,
  output logic regulator_bypass_bit,
  output logic high_perf_supply_mode,
  output logic low_power_supply_mode,
  output logic pa_enable,
  output logic [1:0] battery_thr_sel,
  output logic [11:0] battery_thr_mv,
  output logic dig_clk_div2,
  // reset outputs
  output logic internal_reset_n,
  output logic first_io_pin,
  output logic io_disable_signal,
  output logic soft_reset_out
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [3:0] pins_s;
  pcr_sync #(.W(4)) u_sync (
    .aclk(aclk),
    .ce(ce),
    .d({shutdown_pin, battery_low, tx_state, rx_state}),
    .q(pins_s)
  );
  logic sdn_s, bat_s, tx_s, rx_s;
  assign sdn_s = pins_s[3];
  assign bat_s = pins_s[2];
  assign tx_s = pins_s[1];
  assign rx_s = pins_s[0];

  // ****************************************
  // reset sequencer
  // ****************************************
  pcr_pkg::pcr_rst_e st_r, st_nxt;
  logic [19:0] cnt_r, cnt_nxt;
  logic sdn_prev_r;
  logic sdn_fall;
  logic soft_cmd;
  logic full_rst; // registers return to defaults while this is high
  assign sdn_fall = sdn_prev_r & ~sdn_s;
  assign full_rst = (st_r == pcr_pkg::PCR_ST_HOLD);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      pcr_pkg::PCR_ST_HOLD: begin
        // shutdown high keeps the device in reset; fall restarts pulse
        if (sdn_s)
          cnt_nxt = '0;
        else if (cnt_r >= 20'(RESET_CYCLES - 1)) begin
          st_nxt = pcr_pkg::PCR_ST_RUN;
          cnt_nxt = '0;
        end else
          cnt_nxt = cnt_r + 20'h1;
      end
      pcr_pkg::PCR_ST_RUN: begin
        if (sdn_s || sdn_fall) begin
          st_nxt = pcr_pkg::PCR_ST_HOLD;
          cnt_nxt = '0;
        end else if (soft_cmd) begin
          st_nxt = pcr_pkg::PCR_ST_SOFT;
          cnt_nxt = '0;
        end
      end
      pcr_pkg::PCR_ST_SOFT: begin
        if (sdn_s) begin
          st_nxt = pcr_pkg::PCR_ST_HOLD;
          cnt_nxt = '0;
        end else if (cnt_r >= 20'(pcr_pkg::SOFT_RST_CYC - 1)) begin
          st_nxt = pcr_pkg::PCR_ST_RUN;
          cnt_nxt = '0;
        end else
          cnt_nxt = cnt_r + 20'h1;
      end
      default: begin
        st_nxt = pcr_pkg::PCR_ST_HOLD;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= pcr_pkg::PCR_ST_HOLD;
      cnt_r <= '0;
      sdn_prev_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sdn_prev_r <= sdn_s;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [2:0] lvl_r;
  logic bypass_r, scope_r, ratio_en_r, bat_prot_r, div2_r;
  logic [14:0] ratio_r;
  logic [1:0] bat_thr_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic aw_take, w_take;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
  assign wd = w_hold_r ? wdata_r : s_axi_wdata;
  assign ws = w_hold_r ? wstrb_r : s_axi_wstrb;
  assign do_write = (aw_hold_r | aw_take) & (w_hold_r | w_take) &
                    ~s_axi_bvalid;
  logic wr_ok;
  assign wr_ok = (wa == pcr_pkg::ADDR_SUPPLY_A) |
                 (wa == pcr_pkg::ADDR_SUPPLY_B) |
                 (wa == pcr_pkg::ADDR_RATIO_LO) |
                 (wa == pcr_pkg::ADDR_RATIO_HI) |
                 (wa == pcr_pkg::ADDR_CONTROL) |
                 (wa == pcr_pkg::ADDR_STATUS);
  logic wr_a, wr_b, wr_lo, wr_hi, wr_c;
  assign wr_a = do_write & ws[0] & (wa == pcr_pkg::ADDR_SUPPLY_A);
  assign wr_b = do_write & ws[0] & (wa == pcr_pkg::ADDR_SUPPLY_B);
  assign wr_lo = do_write & ws[0] & (wa == pcr_pkg::ADDR_RATIO_LO);
  assign wr_hi = do_write & ws[0] & (wa == pcr_pkg::ADDR_RATIO_HI);
  assign wr_c = do_write & ws[0] & (wa == pcr_pkg::ADDR_CONTROL);
  // soft reset bit is self clearing: a write of one starts the sequence
  assign soft_cmd = wr_c & wd[pcr_pkg::SOFT_RST_BIT];
  logic soft_act;
  assign soft_act = (st_r == pcr_pkg::PCR_ST_SOFT);

  always_ff @(posedge aclk) begin
    if (!aresetn || full_rst) begin
      lvl_r <= pcr_pkg::LVL_RST;
      bypass_r <= 1'b0;
      scope_r <= 1'b0;
      ratio_en_r <= 1'b1;
      ratio_r <= pcr_pkg::RATIO_RST;
      bat_prot_r <= 1'b0;
      bat_thr_r <= 2'h0;
      div2_r <= 1'b0;
    end else if (ce) begin
      if (wr_a)
        lvl_r <= wd[pcr_pkg::LVL_LSB +: pcr_pkg::LVL_W];
      if (wr_b) begin
        bypass_r <= wd[pcr_pkg::BYPASS_BIT];
        scope_r <= wd[pcr_pkg::SCOPE_BIT];
      end
      if (wr_lo)
        ratio_r[7:0] <= wd[7:0];
      if (wr_hi) begin
        ratio_r[14:8] <= wd[6:0];
        ratio_en_r <= wd[pcr_pkg::RATIO_EN_BIT];
      end
      if (wr_c) begin
        bat_prot_r <= wd[pcr_pkg::BAT_PROT_BIT];
        bat_thr_r <= wd[pcr_pkg::BAT_THR_LSB +: 2];
        div2_r <= wd[pcr_pkg::DIV2_BIT];
      end
    end
  end

  // ****************************************
  // axi write channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (ce) begin
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else begin
        if (aw_take) begin
          aw_hold_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
        end
        if (w_take) begin
          w_hold_r <= 1'b1;
          wdata_r <= s_axi_wdata;
          wstrb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= ~aw_hold_r & ~aw_take & ~s_axi_bvalid & ~do_write;
      s_axi_wready <= ~w_hold_r & ~w_take & ~s_axi_bvalid & ~do_write;
    end
  end

  // ****************************************
  // axi read channel
  // ****************************************
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [31:0] status_word;
  assign status_word = {26'h0, soft_act, pa_enable, bat_s, sdn_s,
                        regulator_bypass_bit, internal_reset_n};
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      pcr_pkg::ADDR_SUPPLY_A: rd_mux = {29'h0, lvl_r};
      pcr_pkg::ADDR_SUPPLY_B: rd_mux = {29'h0, scope_r, bypass_r, 1'b0};
      pcr_pkg::ADDR_RATIO_LO: rd_mux = {24'h0, ratio_r[7:0]};
      pcr_pkg::ADDR_RATIO_HI: rd_mux = {24'h0, ratio_en_r, ratio_r[14:8]};
      pcr_pkg::ADDR_CONTROL:
        rd_mux = {27'h0, div2_r, bat_thr_r, bat_prot_r, 1'b0};
      pcr_pkg::ADDR_STATUS: rd_mux = status_word;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // converter level and supply mode
  // ****************************************
  logic [2:0] lvl_eff;
  // receive with scope set forces 1.4 V, transmit uses programmed code
  assign lvl_eff = (scope_r && rx_s && !tx_s) ? pcr_pkg::LVL_FIXED_RX
                   : lvl_r;
  logic [11:0] mv_eff;
  // code 000b is left undecoded and reads as the 1.1 V extrapolation
  assign mv_eff = 12'(pcr_pkg::MV_BASE + pcr_pkg::MV_STEP * 12'(lvl_eff)
                  - pcr_pkg::MV_STEP);
  logic [11:0] bat_mv;
  assign bat_mv = 12'(pcr_pkg::BAT_MV_BASE +
                  pcr_pkg::BAT_MV_STEP * 12'(bat_thr_r));

  logic sw_clk_w;
  pcr_swclk #(.RW(pcr_pkg::RATIO_W)) u_swclk (
    .aclk(aclk),
    .aresetn(aresetn & ~full_rst),
    .ce(ce),
    .ratio_en(ratio_en_r),
    .ratio(ratio_r),
    .sw_clk(sw_clk_w)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_level_code <= pcr_pkg::LVL_RST;
      converter_mv <= 12'h000;
      converter_sw_clk <= 1'b0;
      regulator_bypass_bit <= 1'b0;
      high_perf_supply_mode <= 1'b1;
      low_power_supply_mode <= 1'b0;
      pa_enable <= 1'b0;
      battery_thr_sel <= 2'h0;
      battery_thr_mv <= 12'h000;
      dig_clk_div2 <= 1'b0;
      internal_reset_n <= 1'b0;
      first_io_pin <= 1'b0;
      io_disable_signal <= 1'b0;
      soft_reset_out <= 1'b0;
    end else if (ce) begin
      converter_level_code <= lvl_eff;
      converter_mv <= mv_eff;
      converter_sw_clk <= sw_clk_w;
      regulator_bypass_bit <= bypass_r;
      high_perf_supply_mode <= ~bypass_r;
      low_power_supply_mode <= bypass_r;
      // protection only cuts the amplifier when enabled by the host
      pa_enable <= tx_s & ~(bat_prot_r & bat_s);
      battery_thr_sel <= bat_thr_r;
      battery_thr_mv <= bat_mv;
      dig_clk_div2 <= div2_r;
      internal_reset_n <= ~full_rst;
      first_io_pin <= ~full_rst;
      io_disable_signal <= sdn_s;
      soft_reset_out <= soft_act;
    end
  end
endmodule : pcr_top
`default_nettype wire

// >>> dv/pcr_top_chk.sv
// checker: bus handshake and reset sequencing properties of pcr_top
`timescale 1ns/100ps
`default_nettype none
module pcr_top_chk #(
  parameter int RESET_CYCLES = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic shutdown_pin,
  input wire logic internal_reset_n,
  input wire logic first_io_pin,
  input wire logic io_disable_signal,
  input wire logic soft_reset_out,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // helpers
  // ****************
  // low time of the reset output; a shutdown restarts the count
  int lo_n;
  always_ff @(posedge aclk) begin
    if (!aresetn || internal_reset_n || io_disable_signal) begin
      lo_n <= 0;
    end else begin
      lo_n <= lo_n + 1;
    end
  end
  sequence aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_take;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence soft_pulse;
    soft_reset_out [*4] ##1 !soft_reset_out;
  endsequence
  // ****************
  // properties
  // ****************
  rst_width_a: assert property ($rose(internal_reset_n) |->
    lo_n inside {[RESET_CYCLES - 2 : RESET_CYCLES + 2]})
    else $error("reset pulse width wrong");
  io_mirror_a: assert property (first_io_pin == internal_reset_n)
    else $error("first io pin differs from reset");
  io_on_a: assert property (shutdown_pin [*5] |-> io_disable_signal)
    else $error("io disable missing");
  io_off_a: assert property (!shutdown_pin [*5] |-> !io_disable_signal)
    else $error("io disable stuck");
  sdn_hold_a: assert property (io_disable_signal [*2] |->
    !internal_reset_n) else $error("reset released in shutdown");
  soft_len_a: assert property ($rose(soft_reset_out) |-> soft_pulse)
    else $error("soft reset length wrong");
  soft_part_a: assert property (soft_reset_out |-> internal_reset_n)
    else $error("soft reset became full reset");
  wr_resp_a: assert property (aw_take and w_take |=> s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
endmodule : pcr_top_chk
bind pcr_top pcr_top_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
  .aclk, .aresetn, .shutdown_pin, .internal_reset_n, .first_io_pin,
  .io_disable_signal, .soft_reset_out, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// >>> dv/pcr_top_tb.sv
// testbench: register access, supply control and reset sequencing
`timescale 1ns/100ps
`default_nettype none
module pcr_top_tb;
  // short reset pulse keeps the run brief
  localparam int RST_N = 20;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, shutdown_pin = 1'h0;
  logic battery_low = 1'h0, tx_state = 1'h0, rx_state = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  // answers are accepted one cycle late so held responses are exercised
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, converter_sw_clk, regulator_bypass_bit, pa_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, battery_thr_sel;
  logic [2:0] converter_level_code;
  logic [11:0] converter_mv, battery_thr_mv;
  logic high_perf_supply_mode, low_power_supply_mode, dig_clk_div2;
  logic internal_reset_n, first_io_pin, io_disable_signal, soft_reset_out;
  int n_mismatch = 0, n_compared = 0, cyc = 0, i, k, m_lvl;
  pcr_top #(.RESET_CYCLES(RST_N)) u_dut (
    .aclk, .aresetn, .ce, .shutdown_pin, .battery_low, .tx_state,
    .rx_state, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .converter_level_code, .converter_mv,
    .converter_sw_clk, .regulator_bypass_bit, .high_perf_supply_mode,
    .low_power_supply_mode, .pa_enable, .battery_thr_sel,
    .battery_thr_mv, .dig_clk_div2, .internal_reset_n, .first_io_pin,
    .io_disable_signal, .soft_reset_out
  );
  always #50 aclk = ~aclk;
  // ****************
  // tasks
  // ****************
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic st;
    repeat (5) @(posedge aclk);
  endtask : st
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1 && s_axi_bready !== 1'h1)
        s_axi_bready <= 1'h1;
    end while (s_axi_bvalid !== 1'h1 || s_axi_bready !== 1'h1);
    chk("bresp", s_axi_bresp, r);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1 && s_axi_rready !== 1'h1)
        s_axi_rready <= 1'h1;
    end while (s_axi_rvalid !== 1'h1 || s_axi_rready !== 1'h1);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, r);
  endtask : rc
  // model: receive with scope set forces code 3, target is 1100 + 100 * code
  task automatic lv(input int c);
    st();
    chk("level", converter_level_code, c);
    chk("mv", converter_mv, 1100 + 100 * c);
  endtask : lv
  task automatic per(input int e);
    logic l;
    int n, t, d;
    l = converter_sw_clk;
    t = 0;
    d = 0;
    for (n = 0; n < 70; n++) begin
      @(posedge aclk);
      if (converter_sw_clk && !l) begin
        d = n - t;
        t = n;
      end
      l = converter_sw_clk;
    end
    chk("period", d, e);
  endtask : per
  task automatic rst;
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    k = 0;
    while (internal_reset_n !== 1'h1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    rc(8'h00, 32'h3);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'hFC);
    rc(8'h0C, 32'h87);
    rc(8'h10, 32'h0);
    rc(8'h14, 32'h1);
  endtask : rst
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend
  task stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ****************
  // sequence
  // ****************
  initial begin
    k = $urandom(43);
    rst();
    tend("reset");
    tx_state <= 1'h1;
    for (i = 1; i < 8; i++) begin
      wr(8'h00, i);
      lv(i);
    end
    m_lvl = $urandom_range(7, 4);
    wr(8'h00, m_lvl);
    wr(8'h04, 32'h4);
    tx_state <= 1'h0;
    rx_state <= 1'h1;
    lv(3);
    tx_state <= 1'h1;
    rx_state <= 1'h0;
    lv(m_lvl);
    wr(8'h04, 32'h0);
    tx_state <= 1'h0;
    rx_state <= 1'h1;
    lv(m_lvl);
    tend("level");
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h2);
    st();
    chk("mode", {regulator_bypass_bit, low_power_supply_mode,
                 high_perf_supply_mode}, 3'h6);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h0);
    st();
    chk("mode", {regulator_bypass_bit, low_power_supply_mode,
                 high_perf_supply_mode}, 3'h1);
    tend("mode");
    wr(8'h0C, 32'h0);
    per(4);
    k = $urandom_range(13, 11);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h80 | (1 << (k - 8)));
    per(32768 >> k);
    tend("switch clock");
    tx_state <= 1'h1;
    rx_state <= 1'h0;
    battery_low <= 1'h1;
    for (i = 0; i < 4; i++) begin
      wr(8'h10, 32'h12 | (i << 2));
      st();
      chk("thr_sel", battery_thr_sel, i);
      chk("thr_mv", battery_thr_mv, 2100 + 200 * i);
      chk("pa_off", pa_enable, 0);
    end
    chk("div2", dig_clk_div2, 1);
    wr(8'h10, 32'h0);
    st();
    chk("pa_on", pa_enable, 1);
    tend("battery");
    wr(8'h00, 32'h5);
    wr(8'h10, 32'h1);
    k = 0;
    repeat (8) begin
      @(posedge aclk);
      if (soft_reset_out === 1'h1) k++;
    end
    chk("soft_seen", k > 0, 1);
    rc(8'h00, 32'h5);
    tend("soft reset");
    shutdown_pin <= 1'h1;
    // one microsecond is ten clock periods
    repeat (10) @(posedge aclk);
    chk("io_dis", io_disable_signal, 1);
    chk("rst_low", internal_reset_n, 0);
    chk("io0", first_io_pin, 0);
    shutdown_pin <= 1'h0;
    k = 0;
    while (internal_reset_n !== 1'h1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    chk("pulse", k >= RST_N && k <= RST_N + 6, 1);
    chk("io0", first_io_pin, 1);
    rc(8'h00, 32'h3);
    tend("shutdown");
    rc(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'h1, 2'h2);
    tx_state <= 1'h0;
    battery_low <= 1'h0;
    wr(8'h00, 32'h7);
    rst();
    tend("unmapped and second reset");
    stop_test();
  end
endmodule : pcr_top_tb
`default_nettype wire
